//--- hdl/cccfg_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "cccfg_map.svh"

module cccfg_core import cccfg_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Candidate source clocks from pins and other domains.
  input wire logic codec_io_pin_in,
  input wire logic pll2_clk_in,
  input wire logic i2s_bit_clock_in,
  input wire logic aux_audio_serial_clk_in,
  input wire logic aux_clk4_in,
  input wire logic pll1_clk_in,
  // Codec pin drive for a digital microphone.
  output logic codec_io_pin_out,
  output logic codec_io_pin_oe,
  // Converter clocks as level and one-cycle period tick.
  output logic [1:0] rec_clk,
  output logic [1:0] rec_clk_tick,
  output logic play_clk,
  output logic play_clk_tick,
  // Analog front end and playback settings.
  output cccfg_mic_t [1:0] mic_cfg,
  output cccfg_play_t play_cfg
);

  // ========================================================================
  // State.
  cccfg_state_t st;
  cccfg_state_t nx;
  logic [5:0] src_pins;
  logic [5:0] edges;
  logic [2:0][15:0] cfg_w;
  logic [2:0] tied;
  logic [2:0] run;
  logic [2:0] ev;
  logic [2:0][7:0] half;
  logic [2:0] active;

  assign src_pins = {pll1_clk_in, aux_clk4_in, aux_audio_serial_clk_in,
                     i2s_bit_clock_in, pll2_clk_in, codec_io_pin_in};
  assign cfg_w = {st.pclk, st.rclk};
  assign tied = {1'b0, st.rclk[1][`CCCFG_TIE_BIT],
                 st.rclk[0][`CCCFG_TIE_BIT]};

  // The peripheral clock is this clock, so each cycle counts as one
  // half-cycle. Other sources count both edges of the synchronised
  // level; they must stay well below half the rate of clk.
  function automatic logic src_event(input logic [2:0] code,
                                     input logic [5:0] e);
    logic r;
    r = 1'b0;
    unique case (cccfg_src_t'(code))
      SRC_PERIPH: r = 1'b1;
      SRC_IO_PIN: r = e[0];
      SRC_PLL2: r = e[1];
      SRC_I2S: r = e[2];
      SRC_AUX_SCK: r = e[3];
      SRC_AUX4: r = e[4];
      SRC_PLL1: r = e[5];
      SRC_NONE: r = 1'b0;
    endcase
    return r;
  endfunction : src_event

  // ========================================================================
  // Next-state logic.
  always_comb begin
    nx = st;
    nx.sync[0] = src_pins;
    nx.sync[1] = st.sync[0];
    nx.sync[2] = st.sync[1];
    // A source edge counts once the second and third stages disagree.
    edges = st.sync[1] ^ st.sync[2];

    if (wr) begin
      case (addr)
        `CCCFG_IDX_ANA1: nx.ana[0] = wdata & `CCCFG_ANA_MASK;
        `CCCFG_IDX_ANA2: nx.ana[1] = wdata & `CCCFG_ANA_MASK;
        `CCCFG_IDX_RCLK1: nx.rclk[0] = wdata & `CCCFG_RCLK_MASK;
        `CCCFG_IDX_RCLK2: nx.rclk[1] = wdata & `CCCFG_RCLK_MASK;
        `CCCFG_IDX_PCLK: nx.pclk = wdata & `CCCFG_PCLK_MASK;
        default: begin
        end
      endcase
    end

    // Dividers: 0 and 1 record, 2 playback. A setup change takes effect
    // on the next source edge without restarting the period, which is
    // only safe while the running count does not exceed the new divisor.
    for (int k = 0; k < 3; k++) begin
      run[k] = (cfg_w[k][`CCCFG_DIV_LSB +: 8] != 8'h00) &&
               (cfg_w[k][`CCCFG_SRC_LSB +: 3] != SRC_NONE) &&
               !tied[k];
      ev[k] = src_event(cfg_w[k][`CCCFG_SRC_LSB +: 3], edges);
      half[k] = 8'((9'(cfg_w[k][`CCCFG_DIV_LSB +: 8]) + 9'h001) >> 1);
      nx.div_tick[k] = 1'b0;
      if (!run[k]) begin
        nx.cnt[k] = 8'h00;
        nx.div_lvl[k] = 1'b0;
      end else if (ev[k]) begin
        if (st.cnt[k] == cfg_w[k][`CCCFG_DIV_LSB +: 8]) begin
          nx.cnt[k] = 8'h00;
          nx.div_lvl[k] = 1'b1;
          nx.div_tick[k] = 1'b1;
        end else begin
          nx.cnt[k] = st.cnt[k] + 8'h01;
          if (st.cnt[k] + 8'h01 == half[k]) begin
            nx.div_lvl[k] = 1'b0;
          end
        end
      end
    end

    for (int k = 0; k < 2; k++) begin
      nx.rec_tick[k] = tied[k] ? nx.div_tick[2] : nx.div_tick[k];
      nx.rec_clk[k] = tied[k] ? nx.div_lvl[2] : nx.div_lvl[k];
      nx.mic[k].gain = nx.ana[k][`CCCFG_GAIN_LSB +: 4];
      nx.mic[k].single_ended = nx.ana[k][`CCCFG_MODE_BIT];
      nx.mic[k].digital = nx.ana[k][`CCCFG_MIC_SOURCE_SEL_BIT];
      nx.mic[k].mute_analog = nx.ana[k][`CCCFG_MUTE_BIT];
      // Only channel 1 can silence its digital microphone path.
      nx.mic[k].mute_digital = (k == 0) &&
                               nx.ana[k][`CCCFG_MUTE_BIT];
      // The reserved code falls back to bypass rather than an odd filter.
      nx.mic[k].highpass_sel = (nx.ana[k][`CCCFG_HPF_LSB +: 2] == 2'h3) ?
                      HPF_BYPASS :
                      cccfg_hpf_t'(nx.ana[k][`CCCFG_HPF_LSB +: 2]);
      active[k] = tied[k] ? run[2] : run[k];
    end
    active[2] = run[2];

    // A digital microphone takes the pin regardless of GPIO setup;
    // channel 1 wins when both ask for it.
    nx.pin_oe = nx.mic[0].digital | nx.mic[1].digital;
    nx.pin_out = nx.mic[0].digital ? nx.rec_clk[0] :
                 (nx.mic[1].digital & nx.rec_clk[1]);

    nx.play.range = nx.pclk[`CCCFG_RNG_LSB +: 2];
    nx.play.filter_half = nx.pclk[`CCCFG_FSEL_BIT];

    nx.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `CCCFG_IDX_ANA1: nx.rdata = st.ana[0];
        `CCCFG_IDX_ANA2: nx.rdata = st.ana[1];
        `CCCFG_IDX_RCLK1: nx.rdata = st.rclk[0];
        `CCCFG_IDX_RCLK2: nx.rdata = st.rclk[1];
        `CCCFG_IDX_PCLK: nx.rdata = st.pclk;
        `CCCFG_IDX_STAT: nx.rdata = {13'h0000, active};
        default: nx.rdata = 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.ana <= {`CCCFG_ANA_RST, `CCCFG_ANA_RST};
      st.rclk <= {`CCCFG_RCLK_RST, `CCCFG_RCLK_RST};
      st.pclk <= `CCCFG_PCLK_RST;
    end else begin
      st <= nx;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register.
  assign rdata = st.rdata;
  assign codec_io_pin_out = st.pin_out;
  assign codec_io_pin_oe = st.pin_oe;
  assign rec_clk = st.rec_clk;
  assign rec_clk_tick = st.rec_tick;
  assign play_clk = st.div_lvl[2];
  assign play_clk_tick = st.div_tick[2];
  assign mic_cfg = st.mic;
  assign play_cfg = st.play;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_rec_div_zero: assert property (
    (st.rclk[0][7:0] == 8'h00 && !st.rclk[0][11])
      |=> !rec_clk_tick[0] && !rec_clk[0])
    else $error("record divisor zero but clock runs");

  chk_rec_src_none: assert property (
    (st.rclk[1][10:8] == 3'h7 && !st.rclk[1][11])
      |=> !rec_clk_tick[1] && !rec_clk[1])
    else $error("record source none but clock runs");

  chk_tie_follow: assert property (
    st.rclk[0][11] |=> (rec_clk_tick[0] == play_clk_tick) &&
                        (rec_clk[0] == play_clk))
    else $error("tied record clock differs from playback");

  chk_play_period: assert property (
    (play_clk_tick && st.pclk == 16'h0001) ##1 (st.pclk == 16'h0001)
      |-> !play_clk_tick ##1 play_clk_tick)
    else $error("playback period is not divisor plus one");

  chk_play_none: assert property (
    st.pclk[10:8] == 3'h7 |=> !play_clk_tick)
    else $error("playback source none but clock runs");

  chk_mute_paths: assert property (
    !mic_cfg[1].mute_digital &&
    (mic_cfg[0].mute_digital == st.ana[0][12]) &&
    (mic_cfg[1].mute_analog == st.ana[1][12]))
    else $error("mute paths wrong");

  chk_pin_drive: assert property (
    st.ana[0][11] |-> codec_io_pin_oe && codec_io_pin_out == rec_clk[0])
    else $error("digital microphone pin not driven by clock");

  chk_hpf_decode: assert property (
    st.ana[1][14:13] == 2'h3 |-> mic_cfg[1].highpass_sel == HPF_BYPASS)
    else $error("reserved high-pass code not bypassed");

  chk_range_hint: assert property (
    play_cfg.range == st.pclk[12:11] &&
    play_cfg.filter_half == st.pclk[13])
    else $error("playback hints do not follow register");

  // A tied channel is only a copy of the playback divider, so both
  // channels are held against it, and the own-divider checks skip ties.
  chk_tie_follow_two: assert property (
    st.rclk[1][11] |=> (rec_clk_tick[1] == play_clk_tick) &&
                        (rec_clk[1] == play_clk))
    else $error("tied record clock two differs from playback");

  chk_rec_zero_two: assert property (
    (st.rclk[1][7:0] == 8'h00 && !st.rclk[1][11])
      |=> !rec_clk_tick[1] && !rec_clk[1])
    else $error("record divisor two zero but clock runs");

  chk_play_zero: assert property (
    st.pclk[7:0] == 8'h00 |=> !play_clk_tick && !play_clk)
    else $error("playback divisor zero but clock runs");

  // Three cycles of the peripheral clock prove odd periods work.
  chk_rec_period: assert property (
    (rec_clk_tick[0] && st.rclk[0] == 16'h0002) ##1
    (st.rclk[0] == 16'h0002) [*2]
      |-> !$past(rec_clk_tick[0]) && !rec_clk_tick[0] ##1 rec_clk_tick[0])
    else $error("record period is not divisor plus one");

  chk_tick_level: assert property (
    (!play_clk_tick || play_clk) &&
    (!rec_clk_tick[0] || rec_clk[0]) &&
    (!rec_clk_tick[1] || rec_clk[1]))
    else $error("clock level low at period start");

  chk_gain_mode: assert property (
    (mic_cfg[0].gain == st.ana[0][3:0]) &&
    (mic_cfg[1].gain == st.ana[1][3:0]) &&
    (mic_cfg[0].single_ended == st.ana[0][6]) &&
    (mic_cfg[1].single_ended == st.ana[1][6]))
    else $error("gain or input mode does not follow register");

  chk_hpf_pass: assert property (
    st.ana[0][14:13] != 2'h3 |-> mic_cfg[0].highpass_sel == st.ana[0][14:13])
    else $error("high-pass code not passed through");

  chk_pin_release: assert property (
    !st.ana[0][11] && !st.ana[1][11] |-> !codec_io_pin_oe)
    else $error("codec pin driven without digital microphone");

endmodule : cccfg_core
`default_nettype wire

//--- shared/cccfg_map.svh
`ifndef CCCFG_MAP_SVH
`define CCCFG_MAP_SVH

// ==========================================================================
// Register indices on the plain register port.
`define CCCFG_IDX_ANA1 3'h0
`define CCCFG_IDX_ANA2 3'h1
`define CCCFG_IDX_RCLK1 3'h2
`define CCCFG_IDX_RCLK2 3'h3
`define CCCFG_IDX_PCLK 3'h4
`define CCCFG_IDX_STAT 3'h5

// ==========================================================================
// Reset values and writable-bit masks.
`define CCCFG_ANA_RST 16'h0000
`define CCCFG_RCLK_RST 16'h0000
`define CCCFG_PCLK_RST 16'h0000
`define CCCFG_ANA_MASK 16'h784f
`define CCCFG_RCLK_MASK 16'h0fff
`define CCCFG_PCLK_MASK 16'h3fff

// ==========================================================================
// Field positions.
`define CCCFG_GAIN_LSB 0
`define CCCFG_MODE_BIT 6
`define CCCFG_MIC_SOURCE_SEL_BIT 11
`define CCCFG_MUTE_BIT 12
`define CCCFG_HPF_LSB 13
`define CCCFG_DIV_LSB 0
`define CCCFG_SRC_LSB 8
`define CCCFG_TIE_BIT 11
`define CCCFG_RNG_LSB 11
`define CCCFG_FSEL_BIT 13

`endif

//--- shared/cccfg_pkg.sv
`default_nettype none

package cccfg_pkg;

  typedef enum logic [2:0] {
    SRC_PERIPH = 3'h0,
    SRC_IO_PIN = 3'h1,
    SRC_PLL2 = 3'h2,
    SRC_I2S = 3'h3,
    SRC_AUX_SCK = 3'h4,
    SRC_AUX4 = 3'h5,
    SRC_PLL1 = 3'h6,
    SRC_NONE = 3'h7
  } cccfg_src_t;

  typedef enum logic [1:0] {
    HPF_BYPASS = 2'h0,
    HPF_HIGH_CUT = 2'h1,
    HPF_LOW_CUT = 2'h2
  } cccfg_hpf_t;

  typedef struct packed {
    logic [3:0] gain;
    logic single_ended;
    logic digital;
    logic mute_analog;
    logic mute_digital;
    cccfg_hpf_t highpass_sel;
  } cccfg_mic_t;

  typedef struct packed {
    logic [1:0] range;
    logic filter_half;
  } cccfg_play_t;

  typedef struct packed {
    logic [1:0][15:0] ana;
    logic [1:0][15:0] rclk;
    logic [15:0] pclk;
    logic [2:0][5:0] sync;
    logic [2:0][7:0] cnt;
    logic [2:0] div_tick;
    logic [2:0] div_lvl;
    logic [1:0] rec_tick;
    logic [1:0] rec_clk;
    logic pin_out;
    logic pin_oe;
    cccfg_mic_t [1:0] mic;
    cccfg_play_t play;
    logic [15:0] rdata;
  } cccfg_state_t;

endpackage : cccfg_pkg

`default_nettype wire

//--- testbench/cccfg_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "cccfg_map.svh"

module codec_converter_clock_and_input_config_test import cccfg_pkg::*;;
  // ========================================================================
  // Stimulus and observed signals.
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [5:0] srcs = 6'h00;
  logic pin_out, pin_oe, play_clk, play_tick;
  logic [1:0] rec_clk, rec_tick;
  logic [2:0] tk;
  cccfg_mic_t [1:0] mic;
  cccfg_play_t play;
  int cnt = 0;
  int n_fail = 0;
  int samples_checked = 0;
  int p, n, k;

  assign tk = {play_tick, rec_tick};

  always #10 clk = ~clk;

  // Each source toggles at its own rate so a wrong selection shows up
  // as a wrong period.
  always @(posedge clk) begin
    cnt <= cnt + 1;
    for (int i = 0; i < 6; i++) begin
      if (cnt % (i + 2) == 0) srcs[i] <= ~srcs[i];
    end
  end

  cccfg_core dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .codec_io_pin_in(srcs[0]),
    .pll2_clk_in(srcs[1]), .i2s_bit_clock_in(srcs[2]),
    .aux_audio_serial_clk_in(srcs[3]), .aux_clk4_in(srcs[4]),
    .pll1_clk_in(srcs[5]), .codec_io_pin_out(pin_out),
    .codec_io_pin_oe(pin_oe), .rec_clk(rec_clk), .rec_clk_tick(rec_tick),
    .play_clk(play_clk), .play_clk_tick(play_tick), .mic_cfg(mic),
    .play_cfg(play)
  );

  // ========================================================================
  // Bus and checking tasks.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, e);
    @(posedge clk);
    #1;
    check(rdata, 16'h0000);
  endtask : rd_chk

  // The first two ticks may straddle the settings change, so only the
  // third spacing is returned.
  task automatic period(input int s, output int m);
    m = 0;
    for (int i = 0; i < 3; i++) begin
      m = 0;
      do begin
        @(posedge clk);
        #1;
        m++;
      end while (tk[s] !== 1'b1 && m < 300);
    end
  endtask : period

  task automatic ticks(input int s, output int m);
    m = 0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (tk[s] === 1'b1) m++;
    end
  endtask : ticks

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    #(20 * 30000);
    n_fail++;
    test_done();
  end

  // ========================================================================
  // Test sequence.
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    check(16'({play_clk, rec_clk, pin_oe}), 16'h0000);
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 16'h0000);
    wr_reg(`CCCFG_IDX_ANA1, 16'hffff);
    rd_chk(`CCCFG_IDX_ANA1, `CCCFG_ANA_MASK);
    check(16'(mic[0]), 16'h03fc);
    check(16'(pin_oe), 16'h0001);
    for (int c = 0; c < 2; c++) begin
      wr_reg(3'(c), 16'h1000);
      check(16'(mic[c]), c ? 16'h0008 : 16'h000c);
    end
    for (int i = 0; i < 16; i++) begin
      wr_reg(`CCCFG_IDX_ANA2, 16'(i) | 16'(i % 4) << 13 | 16'(i % 2) << 6);
      check(16'(mic[1]), 16'({4'(i), 1'(i % 2), 3'h0,
        (i % 4 == 3) ? 2'h0 : 2'(i % 4)}));
    end
    for (int r = 0; r < 4; r++) begin
      wr_reg(`CCCFG_IDX_PCLK, 16'h0701 | 16'(r) << 11 | 16'(r % 2) << 13);
      check(16'(play), 16'({2'(r), 1'(r % 2)}));
    end
    ticks(2, n);
    check(16'(n), 16'h0000);
    // Clock setups are also rewritten while the converters run.
    wr_reg(`CCCFG_IDX_PCLK, 16'h0001);
    period(2, p);
    check(16'(p), 16'd2);
    wr_reg(`CCCFG_IDX_PCLK, 16'h0004);
    period(2, p);
    check(16'(p), 16'd5);
    wr_reg(`CCCFG_IDX_PCLK, 16'h0000);
    ticks(2, n);
    check(16'(n), 16'h0000);
    for (int c = 0; c < 7; c++) begin
      wr_reg(`CCCFG_IDX_RCLK1, 16'(c) << 8 | 16'h0002);
      period(0, p);
      check(16'(p), 16'(c ? 3 * (c + 1) : 3));
    end
    wr_reg(`CCCFG_IDX_RCLK1, 16'h0702);
    ticks(0, n);
    check(16'(n), 16'h0000);
    wr_reg(`CCCFG_IDX_RCLK1, 16'h0000);
    ticks(0, n);
    check(16'(n), 16'h0000);
    wr_reg(`CCCFG_IDX_PCLK, 16'h0003);
    wr_reg(`CCCFG_IDX_RCLK2, 16'h0801);
    period(1, p);
    check(16'(p), 16'd4);
    rd_chk(`CCCFG_IDX_STAT, 16'h0006);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (rec_clk[1] !== play_clk) k++;
    end
    check(16'(k), 16'h0000);
    // Channel 1 shares the playback clock, as sidetone use requires.
    wr_reg(`CCCFG_IDX_RCLK1, 16'h0805);
    period(0, p);
    check(16'(p), 16'd4);
    wr_reg(`CCCFG_IDX_RCLK2, 16'h0502);
    period(1, p);
    check(16'(p), 16'd18);
    wr_reg(`CCCFG_IDX_RCLK2, 16'h0702);
    ticks(1, n);
    check(16'(n), 16'h0000);
    // A one-cycle lag between the pin and the converter clock is allowed.
    wr_reg(`CCCFG_IDX_ANA1, 16'h0800);
    wr_reg(`CCCFG_IDX_RCLK1, 16'h0002);
    n = 0;
    k = 0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (pin_out === 1'b1) n++;
      if (rec_clk[0] === 1'b1) k++;
    end
    check(16'(n > 0 && n - k <= 1 && k - n <= 1), 16'h0001);
    wr_reg(`CCCFG_IDX_ANA1, 16'h0000);
    check(16'(pin_oe), 16'h0000);
    test_done();
  end
endmodule : codec_converter_clock_and_input_config_test

`default_nettype wire
